// >>> rtl/ddrci_defs.vh
`ifndef DDRCI_DEFS_VH
`define DDRCI_DEFS_VH
// software register offsets
`define DDRCI_REG_CMD      4'h0
`define DDRCI_REG_ADDR     4'h1
`define DDRCI_REG_CTRL     4'h2
`define DDRCI_REG_WDATA    4'h3
`define DDRCI_REG_STATUS   4'h4
`define DDRCI_REG_RDATA    4'h5
`define DDRCI_REG_REFCNT   4'h6
// command codes written to the command register
`define DDRCI_OP_NOP       3'h0
`define DDRCI_OP_ACT       3'h1
`define DDRCI_OP_RD        3'h2
`define DDRCI_OP_WR        3'h3
`define DDRCI_OP_PRE       3'h4
`define DDRCI_OP_REF       3'h5
`define DDRCI_OP_MRS       3'h6
`define DDRCI_OP_ZQ        3'h7
// field positions in the address register
`define DDRCI_AP_BIT       10
`define DDRCI_BC_BIT       12
`define DDRCI_BA_LSB       16
`define DDRCI_RANK_BIT     19
// control register fields
`define DDRCI_CTRL_CKE0    0
`define DDRCI_CTRL_CKE1    1
`define DDRCI_CTRL_ODT0    2
`define DDRCI_CTRL_ODT1    3
`define DDRCI_CTRL_RSTN    4
`define DDRCI_CTRL_HOT     5
`define DDRCI_CTRL_RESET   6'h00
// timing
`define DDRCI_CLK_NS       50
`define DDRCI_ACTIVATE_TO_COLUMN_DELAY_NS      1375
`define DDRCI_TRP_NS       1375
`define DDRCI_TCL_NS       1375
`define DDRCI_NS_SCALE     100
`define DDRCI_LAT_CLKS     11
`define DDRCI_REF_WIN_MS   64
`define DDRCI_REF_CMDS     8192
`define DDRCI_BURST_LEN    8
`define DDRCI_CHOP_LEN     4
`endif

// >>> rtl/ddrci_host.v
`timescale 1ns/10ps
`default_nettype none
`include "ddrci_defs.vh"
module ddrci_host #(
    parameter DQ_W       = 8,
    parameter LAT_CLKS   = `DDRCI_LAT_CLKS,
    parameter REF_PERIOD = (`DDRCI_REF_WIN_MS * 1000000) / (`DDRCI_REF_CMDS * `DDRCI_CLK_NS)
) (
    input  wire              clock,
    input  wire              srst,
    input  wire [3:0]        sw_addr,
    input  wire [31:0]       sw_wdata,
    input  wire              sw_wr,
    input  wire              sw_rd,
    output reg  [31:0]       sw_rdata,
    output reg  [14:0]       mem_addr,
    output reg  [2:0]        mem_bank,
    output reg  [1:0]        mem_cs_n,
    output reg               mem_ras_n,
    output reg               mem_cas_n,
    output reg               mem_we_n,
    output reg  [1:0]        mem_cke,
    output reg  [1:0]        mem_termination_enable,
    output reg               mem_reset_n,
    output reg  [DQ_W-1:0]   mem_dq_out,
    output reg               mem_dq_oe,
    input  wire [DQ_W-1:0]   mem_dq_in,
    output reg               mem_write_data_mask,
    output reg               mem_dqs_out,
    output reg               mem_dqs_oe,
    input  wire              mem_dqs_in
);
    localparam [4:0] LAT = LAT_CLKS[4:0];
    localparam RP_W = 20;
    localparam [RP_W-1:0] REF_CNT = REF_PERIOD[RP_W-1:0];
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_WAIT = 2'h1;
    localparam [1:0] ST_WBUR = 2'h2;
    localparam [1:0] ST_RBUR = 2'h3;

    reg  [1:0]      state_reg;
    reg  [4:0]      wait_reg;
    reg  [3:0]      beat_reg;
    reg  [3:0]      len_reg;
    reg  [2:0]      op_reg;
    reg  [31:0]     adr_reg;
    reg  [5:0]      ctrl_reg;
    reg  [31:0]     wdata_reg;
    reg  [DQ_W-1:0] rdata_reg;
    reg  [RP_W-1:0] ref_tmr_reg;
    reg             ref_due_reg;
    reg  [15:0]     ref_cnt_reg;
    reg  [7:0]      open_reg;
    reg  [DQ_W-1:0] dq_s1_reg;
    reg  [DQ_W-1:0] dq_s2_reg;
    reg             dqs_s1_reg;
    reg             dqs_s2_reg;
    wire            busy;
    wire            go;
    wire [2:0]      bank;
    wire [2:0]      ref_op;
    wire [RP_W-1:0] ref_lim;
    assign busy    = (state_reg != ST_IDLE);
    assign go      = sw_wr && (sw_addr == `DDRCI_REG_CMD) && !busy;
    assign bank    = adr_reg[`DDRCI_BA_LSB +: 3];
    assign ref_op  = `DDRCI_OP_REF;
    // hot case halves the refresh interval
    assign ref_lim = ctrl_reg[`DDRCI_CTRL_HOT] ? {1'b0, REF_CNT[RP_W-1:1]} : REF_CNT;

    // pin inputs through two flops
    always @(posedge clock)
    begin
        dq_s1_reg  <= mem_dq_in;
        dq_s2_reg  <= dq_s1_reg;
        dqs_s1_reg <= mem_dqs_in;
        dqs_s2_reg <= dqs_s1_reg;
    end

    // software register writes
    always @(posedge clock)
    begin
        if (srst)
        begin
            adr_reg   <= 32'h00000000;
            ctrl_reg  <= `DDRCI_CTRL_RESET;
            wdata_reg <= 32'h00000000;
        end
        else if (sw_wr)
        begin
            case (sw_addr)
                `DDRCI_REG_ADDR:  adr_reg   <= sw_wdata;
                `DDRCI_REG_CTRL:  ctrl_reg  <= sw_wdata[5:0];
                `DDRCI_REG_WDATA: wdata_reg <= sw_wdata;
                default:          ;
            endcase
        end
    end

    // per-rank controls and device reset
    always @(posedge clock)
    begin
        if (srst)
        begin
            mem_cke                <= 2'h0;
            mem_termination_enable <= 2'h0;
            mem_reset_n            <= 1'b0;
        end
        else
        begin
            mem_cke                <= ctrl_reg[1:0];
            mem_termination_enable <= ctrl_reg[3:2];
            mem_reset_n            <= ctrl_reg[`DDRCI_CTRL_RSTN];
        end
    end

    // refresh interval timer
    always @(posedge clock)
    begin
        if (srst)
        begin
            ref_tmr_reg <= {RP_W{1'b0}};
            ref_due_reg <= 1'b0;
            ref_cnt_reg <= 16'h0000;
        end
        else
        begin
            if (ref_tmr_reg >= ref_lim - 1'b1)
                ref_tmr_reg <= {RP_W{1'b0}};
            else
                ref_tmr_reg <= ref_tmr_reg + 1'b1;
            // a new due wins over the clear
            if (ref_tmr_reg >= ref_lim - 1'b1)
                ref_due_reg <= 1'b1;
            else if (go && sw_wdata[2:0] == ref_op)
                ref_due_reg <= 1'b0;
            if (go && sw_wdata[2:0] == ref_op)
                ref_cnt_reg <= ref_cnt_reg + 1'b1;
        end
    end

    // command sequencer and data bursts
    always @(posedge clock)
    begin
        if (srst)
        begin
            state_reg           <= ST_IDLE;
            wait_reg            <= 5'h00;
            beat_reg            <= 4'h0;
            len_reg             <= 4'h0;
            op_reg              <= `DDRCI_OP_NOP;
            open_reg            <= 8'h00;
            rdata_reg           <= {DQ_W{1'b0}};
            mem_cs_n            <= 2'h3;
            mem_ras_n           <= 1'b1;
            mem_cas_n           <= 1'b1;
            mem_we_n            <= 1'b1;
            mem_addr            <= 15'h0000;
            mem_bank            <= 3'h0;
            mem_dq_out          <= {DQ_W{1'b0}};
            mem_dq_oe           <= 1'b0;
            mem_write_data_mask <= 1'b0;
            mem_dqs_out         <= 1'b0;
            mem_dqs_oe          <= 1'b0;
        end
        else
        begin
            mem_cs_n  <= 2'h3;
            mem_ras_n <= 1'b1;
            mem_cas_n <= 1'b1;
            mem_we_n  <= 1'b1;
            case (state_reg)
                ST_IDLE:
                begin
                    mem_dq_oe  <= 1'b0;
                    mem_dqs_oe <= 1'b0;
                    if (go && sw_wdata[2:0] != `DDRCI_OP_NOP)
                    begin
                        op_reg   <= sw_wdata[2:0];
                        // chip select picks the rank
                        mem_cs_n <= adr_reg[`DDRCI_RANK_BIT] ? 2'h1 : 2'h2;
                        mem_bank <= bank;
                        mem_addr <= adr_reg[14:0];
                        // reads also cover the device's registering edge and the two input flops
                        wait_reg <= (sw_wdata[2:0] == `DDRCI_OP_RD) ? LAT + 5'h03 : LAT;
                        state_reg <= ST_WAIT;
                        // strobe encoding per command
                        case (sw_wdata[2:0])
                            `DDRCI_OP_ACT:
                            begin
                                mem_ras_n <= 1'b0;
                                open_reg[bank] <= 1'b1;
                            end
                            `DDRCI_OP_RD:  mem_cas_n <= 1'b0;
                            `DDRCI_OP_WR:
                            begin
                                mem_cas_n <= 1'b0;
                                mem_we_n  <= 1'b0;
                            end
                            `DDRCI_OP_PRE:
                            begin
                                mem_ras_n <= 1'b0;
                                mem_we_n  <= 1'b0;
                                if (adr_reg[`DDRCI_AP_BIT])
                                    open_reg <= 8'h00;
                                else
                                    open_reg[bank] <= 1'b0;
                            end
                            `DDRCI_OP_REF:
                            begin
                                mem_ras_n <= 1'b0;
                                mem_cas_n <= 1'b0;
                            end
                            `DDRCI_OP_MRS:
                            begin
                                mem_ras_n <= 1'b0;
                                mem_cas_n <= 1'b0;
                                mem_we_n  <= 1'b0;
                            end
                            default: mem_we_n <= 1'b0;
                        endcase
                        // chop length from a12
                        len_reg <= adr_reg[`DDRCI_BC_BIT] ? 4'h8 : 4'h4;
                    end
                end
                ST_WAIT:
                begin
                    // spacing of eleven clocks, fourteen after a read
                    wait_reg <= wait_reg - 1'b1;
                    if (wait_reg == 5'h01)
                    begin
                        beat_reg <= 4'h0;
                        if (op_reg == `DDRCI_OP_WR)
                            state_reg <= ST_WBUR;
                        else if (op_reg == `DDRCI_OP_RD)
                            state_reg <= ST_RBUR;
                        else
                            state_reg <= ST_IDLE;
                        if (op_reg == `DDRCI_OP_RD && adr_reg[`DDRCI_AP_BIT])
                            open_reg[bank] <= 1'b0;
                    end
                end
                ST_WBUR:
                begin
                    // one beat per clock, strobe toggles on the same edge as the data
                    mem_dq_oe           <= 1'b1;
                    mem_dqs_oe          <= 1'b1;
                    mem_dq_out          <= wdata_reg[beat_reg[1:0]*DQ_W +: DQ_W];
                    mem_write_data_mask <= wdata_reg[28 + beat_reg[1:0]];
                    mem_dqs_out         <= beat_reg[0];
                    beat_reg            <= beat_reg + 1'b1;
                    if (beat_reg == len_reg - 1'b1)
                    begin
                        state_reg <= ST_IDLE;
                        if (adr_reg[`DDRCI_AP_BIT])
                            open_reg[bank] <= 1'b0;
                    end
                end
                ST_RBUR:
                begin
                    // capture data with the device strobe
                    if (dqs_s2_reg)
                        rdata_reg <= dq_s2_reg;
                    beat_reg <= beat_reg + 1'b1;
                    if (beat_reg == len_reg - 1'b1)
                        state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // read mux, data one cycle later
    always @(posedge clock)
    begin
        if (srst)
            sw_rdata <= 32'h00000000;
        else if (sw_rd)
        begin
            case (sw_addr)
                `DDRCI_REG_ADDR:   sw_rdata <= adr_reg;
                `DDRCI_REG_CTRL:   sw_rdata <= {26'h0, ctrl_reg};
                `DDRCI_REG_WDATA:  sw_rdata <= wdata_reg;
                `DDRCI_REG_STATUS: sw_rdata <= {22'h0, ref_due_reg, busy, open_reg};
                `DDRCI_REG_RDATA:  sw_rdata <= {{(32-DQ_W){1'b0}}, rdata_reg};
                `DDRCI_REG_REFCNT: sw_rdata <= {16'h0, ref_cnt_reg};
                default:           sw_rdata <= 32'h00000000;
            endcase
        end
        else
            sw_rdata <= 32'h00000000;
    end
endmodule // ddrci_host
`default_nettype wire

// >>> dv/ddrci_host_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "ddrci_defs.vh"
module ddrci_chk (
    input wire logic        clock,
    input wire logic        srst,
    input wire logic [3:0]  sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic        sw_wr,
    input wire logic [1:0]  mem_cs_n,
    input wire logic        mem_ras_n,
    input wire logic        mem_cas_n,
    input wire logic        mem_we_n,
    input wire logic [1:0]  mem_cke,
    input wire logic [1:0]  mem_termination_enable,
    input wire logic        mem_reset_n,
    input wire logic        mem_dq_oe,
    input wire logic        mem_dqs_oe,
    input wire logic        mem_dqs_out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // pin-level relations of the command and data side
    chk_rst_idle: assert property ($fell(srst) |-> mem_cs_n == 2'h3 && mem_cke == 2'h0 && !mem_reset_n)
        else $error("pins not idle after reset");
    chk_cs_pulse: assert property (mem_cs_n != 2'h3 |=> mem_cs_n == 2'h3)
        else $error("chip select held too long");
    chk_no_stray: assert property (mem_cs_n == 2'h3 |-> mem_ras_n && mem_cas_n && mem_we_n)
        else $error("command strobe without chip select");
    // control register first, then the pin flops one clock later
    chk_ctrl_pins: assert property (sw_wr && sw_addr == `DDRCI_REG_CTRL |-> ##2
        {mem_reset_n, mem_termination_enable, mem_cke} == $past(sw_wdata[4:0], 2))
        else $error("rank controls do not follow control register");
    chk_cmd_gap: assert property (mem_cs_n != 2'h3 |=> (mem_cs_n == 2'h3) [*8])
        else $error("commands too close");
    // command seen, eleven wait clocks, then the first beat flop
    chk_wr_delay: assert property (mem_cs_n != 2'h3 && mem_ras_n && !mem_cas_n && !mem_we_n |-> ##12 mem_dq_oe)
        else $error("write data not after latency");
    chk_burst_len: assert property ($rose(mem_dq_oe) |->
        (mem_dq_oe [*4] ##1 !mem_dq_oe) or (mem_dq_oe [*8] ##1 !mem_dq_oe))
        else $error("burst length not four or eight");
    chk_dqs_pair: assert property (mem_dq_oe == mem_dqs_oe)
        else $error("strobe enable apart from data");
    chk_dqs_flip: assert property (mem_dq_oe && $past(mem_dq_oe) |-> mem_dqs_out != $past(mem_dqs_out))
        else $error("strobe not toggling per beat");
endmodule // ddrci_chk
bind ddrci_host ddrci_chk ddrci_chk_i (.clock(clock), .srst(srst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
    .mem_cke(mem_cke), .mem_termination_enable(mem_termination_enable), .mem_reset_n(mem_reset_n),
    .mem_dq_oe(mem_dq_oe), .mem_dqs_oe(mem_dqs_oe), .mem_dqs_out(mem_dqs_out));
`default_nettype wire

// >>> dv/ddrci_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module ddrci_mem_model #(parameter LAT = 11) (
    input  wire logic        clock,
    input  wire logic [1:0]  cs_n,
    input  wire logic [1:0]  cke,
    input  wire logic        ras_n,
    input  wire logic        cas_n,
    input  wire logic        we_n,
    input  wire logic [2:0]  bank,
    input  wire logic [14:0] addr,
    output var  logic [7:0]  dq,
    output var  logic        dqs,
    output var  logic        bad
);
    logic [7:0] open_q [2] = '{8'h00, 8'h00};
    int lat = 0;
    int beats = 0;
    wire rk = cs_n[0];
    // a rank whose clock enable is low has its command buffers off
    wire sel = cs_n != 2'h3 && cke[rk];
    initial {dq, dqs, bad} = 10'h000;
    // decode and bank state on the rising crossing
    always @(posedge clock)
    begin
        if (sel && !ras_n && cas_n && we_n) open_q[rk][bank] <= 1'b1;
        if (sel && !ras_n && cas_n && !we_n)
            open_q[rk] <= addr[10] ? 8'h00 : open_q[rk] & ~(8'h01 << bank);
        if (sel && ras_n && !cas_n)
        begin
            if (open_q[rk][bank] !== 1'b1) bad <= 1'b1;
            if (addr[10]) open_q[rk][bank] <= 1'b0;
            if (we_n) lat <= LAT - 1;
            if (we_n) beats <= addr[12] ? 8 : 4;
        end
        else if (lat > 0) lat <= lat - 1;
        // first beat LAT clocks after the command; strobe rests low between bursts
        dqs <= (lat == 0 && beats > 0) ? ~dqs : 1'b0;
        dq <= (lat == 0 && beats > 0) ? 8'hA5 ^ beats[7:0] : ~dq;
        if (lat == 0 && beats > 0) beats <= beats - 1;
    end
endmodule // ddrci_mem_model
`default_nettype wire

// >>> dv/test_dual_rank_ddr3_command_interface.sv
`timescale 1ns/10ps
`default_nettype none
`include "ddrci_defs.vh"
module test_dual_rank_ddr3_command_interface;
    logic clock = 1'b0, srst = 1'b1, sw_wr = 1'b0, sw_rd = 1'b0;
    logic [3:0] sw_addr = 4'h0;
    logic [31:0] sw_wdata = 32'h0, sw_rdata, wd;
    logic [14:0] mem_addr;
    logic [2:0] mem_bank;
    logic [1:0] mem_cs_n, mem_cke, mem_termination_enable;
    logic mem_ras_n, mem_cas_n, mem_we_n, mem_reset_n, mem_dq_oe, mem_dqs_oe, mem_dqs_out, mem_dqs_in;
    logic mem_write_data_mask, bad;
    logic [7:0] mem_dq_out, mem_dq_in;
    int fails = 0, n_tests = 0;
    logic [22:0] cmd_q [$];
    logic [8:0] beat_q [$];
    ddrci_host #(.REF_PERIOD(40)) ddrci_host_i (.clock(clock), .srst(srst), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .mem_addr(mem_addr),
        .mem_bank(mem_bank), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
        .mem_we_n(mem_we_n), .mem_cke(mem_cke), .mem_termination_enable(mem_termination_enable),
        .mem_reset_n(mem_reset_n), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in),
        .mem_write_data_mask(mem_write_data_mask), .mem_dqs_out(mem_dqs_out), .mem_dqs_oe(mem_dqs_oe),
        .mem_dqs_in(mem_dqs_in));
    ddrci_mem_model ddrci_mem_model_i (.clock(clock), .cs_n(mem_cs_n), .cke(mem_cke), .ras_n(mem_ras_n),
        .cas_n(mem_cas_n), .we_n(mem_we_n), .bank(mem_bank), .addr(mem_addr), .dq(mem_dq_in),
        .dqs(mem_dqs_in), .bad(bad));
    initial forever #25 clock = ~clock;
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) fails++;
        if (got !== exp) $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    endtask
    task automatic cmp_cmd(input logic [22:0] got, input logic [22:0] exp);
        cmp_reg({9'h0, got}, {9'h0, exp});
    endtask
    task automatic cmp_beat(input logic [8:0] got, input logic [8:0] exp);
        cmp_reg({23'h0, got}, {23'h0, exp});
    endtask
    // one-cycle register port strobes
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clock);
        sw_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clock);
        sw_rd <= 1'b0;
        @(negedge clock);
        d = sw_rdata;
    endtask
    task automatic idle();
        logic [31:0] s;
        for (int i = 0; i < 40; i++)
        begin
            rd(`DDRCI_REG_STATUS, s);
            if (s[8] === 1'b0) return;
        end
        fails++;
        test_done();
    endtask
    // issue one command and note its pins and beats
    task automatic cmd(input logic [2:0] op, input logic [19:0] a, input bit busy);
        logic [2:0] rcw;
        rcw = op == 1 ? 3'h3 : op == 2 ? 3'h5 : op == 3 ? 3'h4 : op == 4 ? 3'h2 :
              op == 5 ? 3'h1 : op == 6 ? 3'h0 : 3'h6;
        wr(`DDRCI_REG_ADDR, {12'h0, a});
        cmd_q.push_back({a[19] ? 2'h1 : 2'h2, rcw, a[18:16], a[14:0]});
        wr(`DDRCI_REG_CMD, {29'h0, op});
        // mask in use, so the termination strobe function stays off
        for (int i = 0; i < (op == 3 ? (a[12] ? 8 : 4) : 0); i++)
            beat_q.push_back({wd[28 + i % 4], wd[8 * (i % 4) +: 8]});
        if (busy) wr(`DDRCI_REG_CMD, 32'h4);
        idle();
    endtask
    // watcher takes the oldest note per command or beat
    always @(negedge clock)
    begin
        if (!srst && mem_cs_n !== 2'h3)
            cmp_cmd({mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_bank, mem_addr},
                cmd_q.size() ? cmd_q.pop_front() : 23'h0);
        if (!srst && mem_dq_oe === 1'b1)
            cmp_beat({mem_write_data_mask, mem_dq_out},
                beat_q.size() ? beat_q.pop_front() : 9'h1FF);
    end
    initial
    begin
        logic [31:0] d;
        logic [2:0] b;
        d = $urandom(44);
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        rd(`DDRCI_REG_CTRL, d);
        cmp_reg(d, {26'h0, `DDRCI_CTRL_RESET});
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            d = $urandom & 32'h1F;
            wr(`DDRCI_REG_CTRL, d);
            // control register first, pin flops a clock later
            repeat (2) @(negedge clock);
            cmp_reg({mem_reset_n, mem_termination_enable, mem_cke}, d);
        end
        wr(`DDRCI_REG_CTRL, 32'h1F);
        $display("test controls done");
        b = $urandom;
        wd = $urandom;
        wr(`DDRCI_REG_WDATA, wd);
        cmd(1, {1'b0, b, 1'b0, 15'($urandom)}, 0);
        rd(`DDRCI_REG_STATUS, d);
        cmp_reg(d[7:0], 8'h01 << b);
        cmd(3, {1'b0, b, 6'h04, 10'($urandom)}, 0);
        cmd(3, {1'b0, b, 6'h00, 10'($urandom)}, 0);
        cmd(2, {1'b0, b, 6'h05, 10'($urandom)}, 0);
        // last beat with strobe high in an eight-beat burst carries A5 ^ 2
        rd(`DDRCI_REG_RDATA, d);
        cmp_reg(d, 32'h000000A7);
        rd(`DDRCI_REG_STATUS, d);
        cmp_reg(d[7:0], 8'h00);
        cmd(1, {1'b0, b, 1'b0, 15'($urandom)}, 1);
        cmd(4, {1'b0, b, 16'h0000}, 0);
        cmd(4, {1'b0, b, 16'h0400}, 0);
        $display("test access done");
        for (int m = 0; m < 4; m++) cmd(6, {1'b1, 3'(m), 1'b0, 15'($urandom)}, 0);
        rd(`DDRCI_REG_STATUS, d);
        cmp_reg(d[9], 1'b1);
        cmd(5, 20'h80000, 0);
        rd(`DDRCI_REG_REFCNT, d);
        cmp_reg(d, 32'h00000001);
        cmd(7, 20'h00000, 0);
        $display("test modes done");
        cmp_reg({31'h0, bad}, 32'h0);
        cmp_reg(cmd_q.size() + beat_q.size(), 32'h0);
        test_done();
    end
endmodule // test_dual_rank_ddr3_command_interface
`default_nettype wire
